// [icp_pkg.sv]
// Shared constants for the two-wire configuration port
package icp_pkg;
  localparam int unsigned ICP_SYS_HZ = 100_000_000;
  localparam int unsigned ICP_STD_BPS = 100_000;
  localparam int unsigned ICP_FAST_BPS = 400_000;
  localparam int unsigned ICP_HALF_STD = ICP_SYS_HZ / (2 * ICP_STD_BPS);
  localparam int unsigned ICP_HALF_FAST = ICP_SYS_HZ / (2 * ICP_FAST_BPS);
  localparam logic [5:0] ICP_ADDR_HI = 6'h38;
  localparam logic [6:0] ICP_ADDR_FIXED = 7'h70;
  localparam int unsigned ICP_BYTE_BITS = 8;
  localparam int unsigned ICP_TIMEOUT_MS = 25;
  localparam int unsigned ICP_TIMEOUT_CYC = ICP_TIMEOUT_MS * (ICP_SYS_HZ / 1000);
  localparam logic [7:0] ICP_LV_REG = 8'h1b;
  localparam int unsigned ICP_LV_BIT = 7;
  localparam int unsigned ICP_REG_DEPTH = 256;
endpackage

// [icp_if.sv]
// Two-wire bus between host and configuration slave
`timescale 1ns/1ps
interface icp_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Open drain wired-and with pull-up
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o)) ? 1'b0 : 1'b1;
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_h_o,
    output sda_h_oe);
endinterface

// [icp_slave.sv]
// Two-wire configuration slave with register RAM
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Overview of operation
// - Registers reachable only through the serial bus
// - Slave only, matches a 7-bit address
// - Works at 100 and 400 kbps
// - Pointer increments after every data byte
// - Address is six fixed bits plus select pin
// - Without select pin, address is 70h
// - Bytes are eight bits, MSB first
// - Host writes address, pointer, then data
// - Host sets pointer, then reads
// - Read continues while host acknowledges
// - Held data line released after timeout
// - Host sets low-voltage bit below 2.5 V
// --------------------------------------------------------------------------
module icp_slave import icp_pkg::*; #(
  parameter bit HAS_SEL_PIN = 1'b0,
  parameter int unsigned TIMEOUT_CYC = ICP_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  icp_if.dev bus,
  input wire logic addr_sel,
  output logic low_volt_mode,
  output logic busy
);
  typedef enum logic [2:0] {
    ICP_IDLE, ICP_ADDR, ICP_PTR, ICP_WDATA, ICP_RDATA, ICP_ACK, ICP_RACK, ICP_SKIP
  } icp_state_t;

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // --------------------------------------------------------------------------
  // Address and register storage
  // --------------------------------------------------------------------------
  logic [6:0] my_addr;
  assign my_addr = HAS_SEL_PIN ? {ICP_ADDR_HI, addr_sel} : ICP_ADDR_FIXED;
  logic [7:0] regs_ff [ICP_REG_DEPTH];
  logic [7:0] ptr_ff;
  logic [7:0] shift_ff;
  logic [3:0] bitcnt_ff;
  logic rw_ff;
  logic ack_ok_ff;
  logic sda_low_ff;
  icp_state_t state_ff;
  icp_state_t ret_ff;
  logic [31:0] hold_cnt_ff;
  logic timeout;
  assign timeout = (hold_cnt_ff >= TIMEOUT_CYC);
  assign low_volt_mode = regs_ff[ICP_LV_REG][ICP_LV_BIT];
  assign busy = (state_ff != ICP_IDLE);
  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = sda_low_ff && !timeout;

  // --------------------------------------------------------------------------
  // Timeout counter on a held data line
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_ff <= 32'h0;
    end else if (!sda_low_ff || scl_rise || scl_fall) begin
      hold_cnt_ff <= 32'h0;
    end else if (!timeout) begin
      hold_cnt_ff <= hold_cnt_ff + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Register write port
  // --------------------------------------------------------------------------
  logic wr_en;
  assign wr_en = (state_ff == ICP_WDATA) && scl_rise && (bitcnt_ff == 4'h7);
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      regs_ff[ptr_ff] <= {shift_ff[6:0], sda_s};
    end
  end

  // --------------------------------------------------------------------------
  // Protocol engine
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ICP_IDLE;
      ret_ff <= ICP_IDLE;
      ptr_ff <= 8'h0;
      shift_ff <= 8'h0;
      bitcnt_ff <= 4'h0;
      rw_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= ICP_ADDR; // pointer kept across restart
      bitcnt_ff <= 4'h0;
      sda_low_ff <= 1'b0;
    end else if (stop_det || timeout) begin
      state_ff <= ICP_IDLE; // pointer kept across stop
      sda_low_ff <= 1'b0;
    end else begin
      case (state_ff)
        ICP_ADDR, ICP_PTR, ICP_WDATA: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (scl_fall && bitcnt_ff == 4'h8) begin
            bitcnt_ff <= 4'h0;
            case (state_ff)
              ICP_ADDR: begin
                if (shift_ff[7:1] == my_addr) begin
                  rw_ff <= shift_ff[0];
                  sda_low_ff <= 1'b1;
                  state_ff <= ICP_ACK;
                  ret_ff <= shift_ff[0] ? ICP_RDATA : ICP_PTR;
                end else begin
                  state_ff <= ICP_SKIP;
                end
              end
              ICP_PTR: begin
                ptr_ff <= shift_ff;
                sda_low_ff <= 1'b1;
                state_ff <= ICP_ACK;
                ret_ff <= ICP_WDATA;
              end
              default: begin
                ptr_ff <= ptr_ff + 8'h1;
                sda_low_ff <= 1'b1;
                state_ff <= ICP_ACK;
                ret_ff <= ICP_WDATA;
              end
            endcase
          end
        end
        ICP_ACK: begin
          if (scl_fall) begin
            state_ff <= ret_ff;
            bitcnt_ff <= 4'h0;
            if (ret_ff == ICP_RDATA) begin
              shift_ff <= regs_ff[ptr_ff];
              sda_low_ff <= !regs_ff[ptr_ff][7];
            end else begin
              sda_low_ff <= 1'b0;
            end
          end
        end
        ICP_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_ff == 4'h7) begin
              sda_low_ff <= 1'b0;
              ptr_ff <= ptr_ff + 8'h1;
              state_ff <= ICP_RACK;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_low_ff <= !shift_ff[6];
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
          end
        end
        ICP_RACK: begin
          if (scl_rise) begin
            ack_ok_ff <= !sda_s;
          end else if (scl_fall) begin
            if (ack_ok_ff) begin
              state_ff <= ICP_RDATA;
              bitcnt_ff <= 4'h0;
              shift_ff <= regs_ff[ptr_ff];
              sda_low_ff <= !regs_ff[ptr_ff][7];
            end else begin
              state_ff <= ICP_SKIP;
            end
          end
        end
        ICP_SKIP: begin
          sda_low_ff <= 1'b0;
        end
        default: begin
          state_ff <= ICP_IDLE;
        end
      endcase
    end
  end
endmodule

// [icp_host.sv]
// Two-wire bus host issuing register writes and reads
`timescale 1ns/1ps
module icp_host import icp_pkg::*; #(
  parameter bit FAST_MODE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  icp_if.host bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [6:0] req_dev,
  input wire logic [7:0] req_reg,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  typedef enum logic [2:0] {
    ICH_IDLE, ICH_START, ICH_BIT, ICH_STOP_A, ICH_STOP_B
  } ich_state_t;
  localparam int unsigned HALF = FAST_MODE ? ICP_HALF_FAST : ICP_HALF_STD;

  // --------------------------------------------------------------------------
  // Sampled data line
  // --------------------------------------------------------------------------
  logic [1:0] sda_sync_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    end
  end

  // --------------------------------------------------------------------------
  // Bit sequencer: phases of 9-bit bytes
  // --------------------------------------------------------------------------
  ich_state_t state_ff;
  logic [8:0] tick_ff;
  logic [1:0] phase_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic second_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic scl_low_ff;
  logic sda_low_ff;
  logic nack_ff;
  logic read_ff;
  logic [6:0] dev_ff;
  logic [7:0] reg_ff;
  logic [7:0] wdat_ff;
  logic tick;
  assign tick = (tick_ff == 9'(HALF - 1));
  assign req_ready = (state_ff == ICH_IDLE);
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_low_ff;
  assign bus.sda_h_o = 1'b0;
  assign bus.sda_h_oe = sda_low_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 9'h0;
    end else if (state_ff == ICH_IDLE || tick) begin
      tick_ff <= 9'h0;
    end else begin
      tick_ff <= tick_ff + 9'h1;
    end
  end

  // Byte to send: address+rw, pointer, data; reads send pointer then restart
  logic [7:0] next_tx;
  always_comb begin
    case (byte_ff)
      2'h0: next_tx = {dev_ff, 1'b0};
      2'h1: next_tx = reg_ff;
      2'h2: next_tx = read_ff ? {dev_ff, 1'b1} : wdat_ff;
      default: next_tx = 8'hff;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ICH_IDLE;
      phase_ff <= 2'h0;
      bit_ff <= 4'h0;
      byte_ff <= 2'h0;
      second_ff <= 1'b0;
      tx_ff <= 8'h0;
      rx_ff <= 8'h0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      nack_ff <= 1'b0;
      read_ff <= 1'b0;
      dev_ff <= 7'h0;
      reg_ff <= 8'h0;
      wdat_ff <= 8'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h0;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_ff)
        ICH_IDLE: begin
          if (req_valid) begin
            read_ff <= req_read;
            dev_ff <= req_dev;
            reg_ff <= req_reg;
            wdat_ff <= req_wdata;
            byte_ff <= 2'h0;
            second_ff <= 1'b0;
            nack_ff <= 1'b0;
            state_ff <= ICH_START;
          end
        end
        ICH_START: begin
          if (tick) begin
            if (scl_low_ff) begin
              scl_low_ff <= 1'b0;
              sda_low_ff <= 1'b0;
            end else if (!sda_low_ff) begin
              sda_low_ff <= 1'b1;
            end else begin
              scl_low_ff <= 1'b1;
              tx_ff <= next_tx;
              bit_ff <= 4'h0;
              phase_ff <= 2'h0;
              state_ff <= ICH_BIT;
            end
          end
        end
        ICH_BIT: begin
          if (tick) begin
            phase_ff <= phase_ff + 2'h1;
            if (phase_ff == 2'h0) begin
              if (bit_ff < 4'h8) begin
                sda_low_ff <= (second_ff && read_ff) ? 1'b0 : !tx_ff[7];
              end else begin
                sda_low_ff <= 1'b0; // Release for slave ACK or last-byte NACK
              end
            end else if (phase_ff == 2'h1) begin
              scl_low_ff <= 1'b0;
            end else if (phase_ff == 2'h2) begin
              if (bit_ff < 4'h8) begin
                rx_ff <= {rx_ff[6:0], sda_sync_ff[1]};
                tx_ff <= {tx_ff[6:0], 1'b0};
              end else if (!(second_ff && read_ff) && sda_sync_ff[1]) begin
                nack_ff <= 1'b1;
              end
            end else begin
              scl_low_ff <= 1'b1;
              phase_ff <= 2'h0;
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h8) begin
                bit_ff <= 4'h0;
                if (nack_ff) begin
                  state_ff <= ICH_STOP_A;
                end else if (second_ff || (byte_ff == 2'h2 && !read_ff)) begin
                  state_ff <= ICH_STOP_A;
                end else if (byte_ff == 2'h1 && read_ff) begin
                  byte_ff <= 2'h2;
                  state_ff <= ICH_START; // restart keeps pointer
                end else if (byte_ff == 2'h2) begin
                  second_ff <= 1'b1;
                  tx_ff <= 8'hff;
                end else begin
                  byte_ff <= byte_ff + 2'h1;
                  tx_ff <= (byte_ff == 2'h0) ? reg_ff : wdat_ff;
                end
              end
            end
          end
        end
        ICH_STOP_A: begin
          if (tick) begin
            sda_low_ff <= 1'b1;
            scl_low_ff <= 1'b0;
            state_ff <= ICH_STOP_B;
          end
        end
        ICH_STOP_B: begin
          if (tick) begin
            sda_low_ff <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_rdata <= rx_ff;
            rsp_nack <= nack_ff;
            state_ff <= ICH_IDLE;
          end
        end
        default: begin
          state_ff <= ICH_IDLE;
        end
      endcase
    end
  end
endmodule

// [icp_if_asserts.sv]
// Concurrent checks on the two-wire bus between host and slave
`timescale 1ns/1ps
module icp_if_asserts import icp_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = ICP_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  // ------------------------------------------------------------------
  // Cycles since last clock line edge
  // ------------------------------------------------------------------
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic scl_ff;
  assign nxt_cnt = (scl != scl_ff) ? 32'h0 : cnt_ff + 32'h1;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 32'h0;
      scl_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      scl_ff <= scl;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  dev_open_drain_a: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drives data line high");
  host_scl_od_a: assert property (scl_oe |-> !scl_o)
    else $error("host drives clock line high");
  host_sda_od_a: assert property (sda_h_oe |-> !sda_h_o)
    else $error("host drives data line high");
  dev_data_stable_a: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device changed data while clock high");
  dev_no_start_a: assert property ((scl && $fell(sda)) |-> !sda_d_oe)
    else $error("device pulled data line low as a start");
  stop_release_a: assert property ((scl && $rose(sda)) |=> !sda_d_oe [*8])
    else $error("device drives data after stop");
  stuck_release_a: assert property ((cnt_ff > TIMEOUT_CYC + 8) |-> !sda_d_oe)
    else $error("device holds data line past timeout");
  scl_high_min_a: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  scl_low_min_a: assert property ($fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
endmodule

// [i2c_config_slave_port_tb.sv]
// Testbench for host and slave joined on the two-wire bus
`timescale 1ns/1ps
module i2c_config_slave_port_tb;
  import icp_pkg::*;
  localparam int unsigned TO = 2000;
  logic clk_sys, arst_n, req_valid, req_ready, req_read, rsp_valid, rsp_nack;
  logic low_volt_mode;
  logic busy;
  logic busy_b;
  logic [6:0] req_dev;
  logic [7:0] req_reg, req_wdata, rsp_rdata, r;
  logic a;
  int num_errors = 0;
  int total_checks = 0;
  icp_if bus();
  icp_if bus2();
  icp_host #(.FAST_MODE(1'b1)) i_icp_host(.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
    .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_dev(req_dev),
    .req_reg(req_reg), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_nack(rsp_nack));
  icp_slave #(.HAS_SEL_PIN(1'b0), .TIMEOUT_CYC(TO)) i_icp_slave(.clk_sys(clk_sys),
    .arst_n(arst_n), .bus(bus), .addr_sel(1'b0), .low_volt_mode(low_volt_mode), .busy(busy));
  icp_slave #(.HAS_SEL_PIN(1'b1), .TIMEOUT_CYC(TO)) i_icp_slave_b(.clk_sys(clk_sys),
    .arst_n(arst_n), .bus(bus2), .addr_sel(1'b1), .low_volt_mode(), .busy(busy_b));
  icp_if_asserts #(.TIMEOUT_CYC(TO)) i_icp_if_asserts(.clk_sys(clk_sys), .arst_n(arst_n),
    .scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .sda_h_o(bus.sda_h_o), .sda_h_oe(bus.sda_h_oe),
    .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe), .scl(bus.scl), .sda(bus.sda));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task host_op(input logic rd, input logic [6:0] dev, input logic [7:0] rg,
    input logic [7:0] wd);
    int n;
    n = 0;
    req_read = rd;
    req_dev = dev;
    req_reg = rg;
    req_wdata = wd;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    tick(1);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 30000) begin
      tick(1);
      n++;
    end
    chk("response", 8'h1, {7'h0, rsp_valid});
  endtask
  // Bench-made link clock, 80 ns period, still between frames
  task bb_bit(input logic b, output logic s);
    tick(1);
    bus2.sda_h_oe = !b;
    tick(3);
    bus2.scl_oe = 1'b0;
    tick(2);
    s = bus2.sda;
    tick(2);
    bus2.scl_oe = 1'b1;
  endtask
  task bb_start;
    bus2.sda_h_oe = 1'b0;
    tick(4);
    bus2.scl_oe = 1'b0;
    tick(4);
    bus2.sda_h_oe = 1'b1;
    tick(4);
    bus2.scl_oe = 1'b1;
  endtask
  task bb_stop;
    bus2.sda_h_oe = 1'b1;
    tick(4);
    bus2.scl_oe = 1'b0;
    tick(4);
    bus2.sda_h_oe = 1'b0;
    tick(4);
  endtask
  task bb_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bb_bit(d[i], q[i]);
    end
  endtask
  task bb_wr(input logic [7:0] d, input logic exp_ack);
    bb_byte(d, r);
    bb_bit(1'b1, a);
    chk("ack", {7'h0, exp_ack}, {7'h0, a});
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_low_volt;
    host_op(1'b0, 7'h70, 8'h1b, 8'h80);
    chk("nack", 8'h0, {7'h0, rsp_nack});
    tick(4);
    chk("busy", 8'h0, {7'h0, busy});
    chk("lv_mode", 8'h1, {7'h0, low_volt_mode});
    host_op(1'b1, 7'h70, 8'h1b, 8'h00);
    chk("rdata", 8'h80, rsp_rdata);
    host_op(1'b0, 7'h70, 8'h1b, 8'h00);
    chk("lv_mode", 8'h0, {7'h0, low_volt_mode});
  endtask
  task t_wrong_dev;
    host_op(1'b0, 7'h70, 8'h10, 8'ha5);
    host_op(1'b0, 7'h71, 8'h10, 8'h5a);
    chk("nack", 8'h1, {7'h0, rsp_nack});
    host_op(1'b1, 7'h70, 8'h10, 8'h00);
    chk("rdata", 8'ha5, rsp_rdata);
  endtask
  task t_burst;
    bb_start();
    bb_wr(8'he0, 1'b1);
    bb_stop();
    bb_start();
    bb_wr(8'he2, 1'b0);
    bb_wr(8'h20, 1'b0);
    bb_wr(8'h3c, 1'b0);
    bb_wr(8'hc3, 1'b0);
    bb_stop();
    bb_start();
    bb_wr(8'he2, 1'b0);
    bb_wr(8'h20, 1'b0);
    bb_stop();
    bb_start();
    bb_wr(8'he3, 1'b0);
    bb_byte(8'hff, r);
    bb_bit(1'b0, a);
    chk("burst0", 8'h3c, r);
    bb_byte(8'hff, r);
    bb_bit(1'b1, a);
    chk("burst1", 8'hc3, r);
    bb_stop();
  endtask
  task t_timeout;
    bb_start();
    bb_byte(8'he2, r);
    bus2.sda_h_oe = 1'b0;
    tick(8);
    chk("held", 8'h1, {7'h0, bus2.sda_d_oe});
    chk("busy_held", 8'h1, {7'h0, busy_b});
    tick(TO + 100);
    chk("released", 8'h0, {7'h0, bus2.sda_d_oe});
    chk("busy_released", 8'h0, {7'h0, busy_b});
    chk("sda_level", 8'h1, {7'h0, bus2.sda});
    bb_stop();
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #990000;
    num_errors++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    {req_valid, req_read, req_dev, req_reg, req_wdata} = '0;
    bus2.scl_o = 1'b0;
    bus2.scl_oe = 1'b0;
    bus2.sda_h_o = 1'b0;
    bus2.sda_h_oe = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    tick(2);
    t_low_volt();
    t_wrong_dev();
    t_burst();
    t_timeout();
    wrap_up();
  end
endmodule
